// ---- verilog/lpm_power_cfg.sv ----
// Sleep and wake power configuration registers and the sleep power sequencer.
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
module lpm_power_cfg
   import lpm_pkg::*;
#(
   parameter int unsigned ADDR_W = 32
) (
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [31:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [31:0]       rdata_o,
   input  wire logic              sleep_enter_i,
   input  wire logic              wake_i,
   input  wire logic              wdog_lock_i,
   input  wire logic              irc_clk_stopped_i,
   output logic                   irc_stop_req_o,
   output logic                   sleep_mode_o,
   output logic      [15:0]       analog_pd_o
);

   // The register addresses are full 32-bit byte addresses.
   if (ADDR_W != 32) begin : g_addr_check
      $error("lpm_power_cfg needs a 32-bit address port");
   end

   typedef struct packed {
      lpm_mode_t   mode;
      logic [15:0] sleep_cfg;
      logic [15:0] wake_cfg;
      logic [31:0] rdata;
      logic [15:0] pd;
   } lpm_state_t;

   lpm_state_t s_q;
   lpm_state_t s_d;
   lpm_run_if  run ();

   logic hit_sleep;
   logic hit_wake;
   logic hit_run;
   logic enter_ok;
   logic wake_ok;

   // Address decode; anything else reads as zero and ignores writes.
   assign hit_sleep = addr_i == LPM_SLEEP_CFG_ADDR;
   assign hit_wake  = addr_i == LPM_WAKE_CFG_ADDR;
   assign hit_run   = addr_i == LPM_RUN_CFG_ADDR;

   // A second sleep request while asleep, or a wake while awake, is ignored.
   assign enter_ok = sleep_enter_i && s_q.mode == LPM_MODE_RUN;
   assign wake_ok  = wake_i && s_q.mode == LPM_MODE_SLEEP;

   // Hardware loads of the run-time word on the two mode changes.
   always_comb begin
      run.wr_en   = wr_i && hit_run;
      run.wr_data = wdata_i[15:0];
      run.load_en = enter_ok || wake_ok;
      // [R1] sleep word copied
      // [R3] lock keeps watchdog running
      // Only the two keepable bits are taken from the sleep word; the rest keep their run value.
      if (enter_ok) begin
         run.load_data = (run.cfg & ~LPM_SLEEP_KEEP_MASK)
                       | (lpm_wdog_guard(s_q.sleep_cfg, wdog_lock_i) & LPM_SLEEP_KEEP_MASK);
      end else begin
         // [R6] wake state restored
         run.load_data = s_q.wake_cfg;
      end
   end

   lpm_run_cfg u_run_cfg (
      .clock_i           (clock_i),
      .rst_n_i           (rst_n_i),
      .irc_clk_stopped_i (irc_clk_stopped_i),
      .irc_stop_req_o    (irc_stop_req_o),
      .run               (run.owner)
   );

   // Next state: register writes, read data, mode and analog power outputs.
   always_comb begin
      s_d = s_q;
      // [R4] brownout sleep bit
      // [R5] watchdog sleep bit
      if (wr_i && hit_sleep) begin
         s_d.sleep_cfg = wdata_i[15:0];
      end
      // [R7] wake bit map
      if (wr_i && hit_wake) begin
         s_d.wake_cfg = wdata_i[15:0];
      end
      // Read data stands for exactly one cycle; the upper half always reads zero.
      s_d.rdata = 32'h0000_0000;
      if (rd_i) begin
         if (hit_sleep) begin
            s_d.rdata = {16'h0000, s_q.sleep_cfg};
         end else if (hit_wake) begin
            s_d.rdata = {16'h0000, s_q.wake_cfg};
         end else if (hit_run) begin
            s_d.rdata = {16'h0000, run.cfg};
         end
      end
      if (enter_ok) begin
         s_d.mode = LPM_MODE_SLEEP;
      end else if (wake_ok) begin
         s_d.mode = LPM_MODE_RUN;
      end
      // [R2] analog blocks forced off
      // Asleep, only the keepable bits follow the loaded run word, so stray run bits cannot leak power.
      if (s_q.mode == LPM_MODE_SLEEP) begin
         s_d.pd = lpm_wdog_guard(run.cfg | ~LPM_SLEEP_KEEP_MASK, wdog_lock_i);
      end else begin
         // [R8] oscillator stop applied
         s_d.pd = lpm_wdog_guard(run.cfg, wdog_lock_i);
         s_d.pd[LPM_INT_OSC_BIT] = run.int_osc_off;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         s_q <= '{mode:      LPM_MODE_RUN,
                  sleep_cfg: LPM_SLEEP_CFG_RST,
                  wake_cfg:  LPM_WAKE_CFG_RST,
                  rdata:     32'h0000_0000,
                  pd:        LPM_RUN_CFG_RST};
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o      = s_q.rdata;
   assign sleep_mode_o = s_q.mode == LPM_MODE_SLEEP;
   assign analog_pd_o  = s_q.pd;

   // Checks run on the system clock and stay quiet while reset is held.
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_enter;
      sleep_enter_i && !sleep_mode_o;
   endsequence

   sequence s_settled_sleep;
      sleep_mode_o [*2];
   endsequence

   sequence s_wake;
      wake_i && sleep_mode_o;
   endsequence

   a_sleep_copy: assert property ( // [R1]
      s_enter |=> run.cfg[LPM_BROWNOUT_BIT] == $past(s_q.sleep_cfg[LPM_BROWNOUT_BIT])
               && run.cfg[LPM_WDOG_OSC_BIT] == ($past(s_q.sleep_cfg[LPM_WDOG_OSC_BIT]) & ~$past(wdog_lock_i)))
      else $error("sleep word not copied into run word on entry");

   a_sleep_forced_off: assert property ( // [R2]
      s_enter ##1 s_settled_sleep |-> (analog_pd_o | LPM_SLEEP_KEEP_MASK) == 16'hFFFF
                                   && analog_pd_o[LPM_BROWNOUT_BIT] == $past(run.cfg[LPM_BROWNOUT_BIT]))
      else $error("analog block left powered while asleep");

   a_lock_wdog_on: assert property ( // [R3]
      wdog_lock_i |=> !analog_pd_o[LPM_WDOG_OSC_BIT])
      else $error("watchdog oscillator stopped while locked");

   a_brownout_reset: assert property ( // [R4]
      $past(!rst_n_i) |-> s_q.sleep_cfg[LPM_BROWNOUT_BIT] == 1'b1)
      else $error("brownout sleep bit not one after reset");

   a_wdog_bit_write: assert property ( // [R5]
      wr_i && hit_sleep |=> s_q.sleep_cfg[LPM_WDOG_OSC_BIT] == $past(wdata_i[LPM_WDOG_OSC_BIT])
                         && s_q.sleep_cfg[LPM_BROWNOUT_BIT] == $past(wdata_i[LPM_BROWNOUT_BIT]))
      else $error("sleep word did not take a write");

   a_wake_restore: assert property ( // [R6]
      wake_i && sleep_mode_o |=> !sleep_mode_o ##0 run.cfg == $past(s_q.wake_cfg))
      else $error("wake state not applied on wake");

   a_wake_bits_reset: assert property ( // [R7]
      $past(!rst_n_i) |-> s_q.wake_cfg[LPM_BROWNOUT_BIT:LPM_INT_OSC_OUT_BIT] == 4'h0)
      else $error("wake bits 3 to 0 not zero after reset");

   a_read_wake: assert property ( // [R7]
      rd_i && hit_wake |=> rdata_o == {16'h0000, $past(s_q.wake_cfg)} ##1 rdata_o == 32'h0000_0000 || $past(rd_i))
      else $error("wake word read back wrong");

   a_flash_follows_run: assert property ( // [R8]
      !sleep_mode_o ##1 !sleep_mode_o |-> analog_pd_o[LPM_NVM_BIT] == $past(run.cfg[LPM_NVM_BIT]))
      else $error("run word write did not reach the analog outputs");

   // Further checks on mode entry, the lock, reset values, read back, wake writes and the analog outputs.
   // The analog outputs lag the run word by one edge, hence the two-cycle look back on wake.
   a_enter_mode: assert property ( // [R2]
      s_enter |=> sleep_mode_o)
      else $error("sleep request did not put the block to sleep");

   a_lock_copy: assert property ( // [R3]
      sleep_enter_i && !sleep_mode_o && wdog_lock_i |=> !run.cfg[LPM_WDOG_OSC_BIT])
      else $error("locked watchdog oscillator copied as off");

   a_wdog_reset: assert property ( // [R5]
      $past(!rst_n_i) |-> s_q.sleep_cfg[LPM_WDOG_OSC_BIT] == 1'b1)
      else $error("watchdog sleep bit not one after reset");

   a_sleep_read: assert property ( // [R4]
      rd_i && hit_sleep |=> rdata_o == {16'h0000, $past(s_q.sleep_cfg)})
      else $error("sleep word read back wrong");

   a_run_read: assert property ( // [R1]
      rd_i && hit_run |=> rdata_o == {16'h0000, $past(run.cfg)})
      else $error("run word read back wrong");

   a_wake_bit_write: assert property ( // [R7]
      wr_i && hit_wake |=> s_q.wake_cfg == $past(wdata_i[15:0]))
      else $error("wake word did not take a write");

   a_out_follows_run: assert property ( // [R8]
      !sleep_mode_o ##1 !sleep_mode_o |-> analog_pd_o[LPM_INT_OSC_OUT_BIT] == $past(run.cfg[LPM_INT_OSC_OUT_BIT]))
      else $error("oscillator output bit did not follow the run word");

   a_wake_analog: assert property ( // [R6]
      s_wake ##1 !sleep_mode_o
      |=> analog_pd_o[LPM_BROWNOUT_BIT:LPM_NVM_BIT] == $past(s_q.wake_cfg[LPM_BROWNOUT_BIT:LPM_NVM_BIT], 2)
       && analog_pd_o[LPM_INT_OSC_OUT_BIT] == $past(s_q.wake_cfg[LPM_INT_OSC_OUT_BIT], 2))
      else $error("wake state did not reach the analog outputs");

endmodule

// ---- verilog/lpm_pkg.sv ----
// Constants, types and helpers shared by the low power mode power configuration block.
// Operation
// [R1] On entry to deep-sleep or power-down the sleep settings are copied into the run-time power register; only sleep bits 3 and 6 are copied.
// [R2] While asleep every analog block is forced off except the brownout detector and watchdog oscillator.
// [R3] With the watchdog lock set, a sleep setting that stops the watchdog oscillator is ignored.
// [R4] Sleep bit 3 powers the brownout detector down when 1, keeps it on when 0, and resets to 1.
// [R5] Sleep bit 6 powers the watchdog oscillator down when 1, keeps it on when 0, and resets to 1.
// [R6] The wake register gives the analog power state applied when leaving deep-sleep or power-down.
// [R7] Wake bits 0 to 3 are oscillator output, oscillator, flash and brownout, 1 meaning off, all reset to 0.
// [R8] A run-time power write acts at once, except oscillator power-down, which waits for a clean clock stop.
// [R9] Software writes reserved sleep bits with their reset values and zeros above bit 15.
package lpm_pkg;

   localparam int unsigned LPM_CFG_W = 16;

   // Byte addresses of the registers on the plain register port.
   localparam logic [31:0] LPM_SLEEP_CFG_ADDR = 32'h4004_8230;
   localparam logic [31:0] LPM_WAKE_CFG_ADDR  = 32'h4004_8234;
   localparam logic [31:0] LPM_RUN_CFG_ADDR   = 32'h4004_8238;

   // Bit positions inside the power configuration words.
   localparam int unsigned LPM_INT_OSC_OUT_BIT = 0;
   localparam int unsigned LPM_INT_OSC_BIT     = 1;
   localparam int unsigned LPM_NVM_BIT         = 2;
   localparam int unsigned LPM_BROWNOUT_BIT    = 3;
   localparam int unsigned LPM_WDOG_OSC_BIT    = 6;

   // Values after reset.
   localparam logic [15:0] LPM_SLEEP_CFG_RST = 16'hFFFF;
   localparam logic [15:0] LPM_WAKE_CFG_RST  = 16'hEDF0;
   localparam logic [15:0] LPM_RUN_CFG_RST   = 16'hEDF0;

   // Blocks that may stay powered while asleep.
   localparam logic [15:0] LPM_SLEEP_KEEP_MASK = 16'h0048;

   typedef enum logic {
      LPM_MODE_RUN   = 1'b0,
      LPM_MODE_SLEEP = 1'b1
   } lpm_mode_t;

   // A locked watchdog keeps its oscillator running whatever the word asks.
   function automatic logic [15:0] lpm_wdog_guard(input logic [15:0] cfg, input logic lock);
      logic [15:0] res;
      res = cfg;
      res[LPM_WDOG_OSC_BIT] = cfg[LPM_WDOG_OSC_BIT] & ~lock;
      return res;
   endfunction

endpackage

// ---- verilog/lpm_run_if.sv ----
// Carrier between the sequencer and the run-time power register.
`timescale 1ns/100ps
interface lpm_run_if;
   logic        wr_en;         // Software write of the run-time word.
   logic [15:0] wr_data;
   logic        load_en;       // Hardware load on sleep entry or wake.
   logic [15:0] load_data;
   logic [15:0] cfg;           // Stored run-time word.
   logic        int_osc_off;   // Oscillator power-down actually applied.

   modport owner (input wr_en, input wr_data, input load_en, input load_data,
                  output cfg, output int_osc_off);
   modport user  (output wr_en, output wr_data, output load_en, output load_data,
                  input cfg, input int_osc_off);
endinterface

// ---- verilog/lpm_run_cfg.sv ----
// Run-time power register with delayed internal oscillator power-down.
`timescale 1ns/100ps
module lpm_run_cfg
   import lpm_pkg::*;
(
   input  wire logic  clock_i,
   input  wire logic  rst_n_i,
   input  wire logic  irc_clk_stopped_i,
   output logic       irc_stop_req_o,
   lpm_run_if.owner   run
);

   typedef struct packed {
      logic [15:0] cfg;
      logic        int_osc_off;
   } lpm_run_state_t;

   lpm_run_state_t s_q;
   lpm_run_state_t s_d;

   // Hardware loads win over a software write in the same cycle.
   always_comb begin
      s_d = s_q;
      if (run.load_en) begin
         s_d.cfg = run.load_data;
      end else if (run.wr_en) begin
         s_d.cfg = run.wr_data;
      end
      // [R8] delayed oscillator stop
      // Power-up acts at once; power-down waits until the clock was stopped cleanly.
      if (!s_d.cfg[LPM_INT_OSC_BIT]) begin
         s_d.int_osc_off = 1'b0;
      end else if (s_q.cfg[LPM_INT_OSC_BIT] && irc_clk_stopped_i) begin
         s_d.int_osc_off = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         s_q <= '{cfg: LPM_RUN_CFG_RST, int_osc_off: LPM_RUN_CFG_RST[LPM_INT_OSC_BIT]};
      end else begin
         s_q <= s_d;
      end
   end

   assign run.cfg         = s_q.cfg;
   assign run.int_osc_off = s_q.int_osc_off;
   // The clock controller is asked to stop the clock while a power-down is pending.
   assign irc_stop_req_o  = s_q.cfg[LPM_INT_OSC_BIT] & ~s_q.int_osc_off;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   a_write_takes_effect: assert property ( // [R8]
      run.wr_en && !run.load_en |=> run.cfg == $past(run.wr_data))
      else $error("run word did not take a software write");

   a_irc_waits_stop: assert property ( // [R8]
      $rose(run.int_osc_off) |-> $past(irc_clk_stopped_i) && $past(irc_stop_req_o))
      else $error("oscillator powered down without a clean clock stop");

endmodule

// ---- verification/lpm_power_cfg_tb_top.sv ----
// Self-checking testbench for the sleep and wake power configuration block.
`timescale 1ns/100ps
module lpm_power_cfg_tb_top;
   import lpm_pkg::*;

   logic        clock_i;
   logic        rst_n_i;
   logic [31:0] addr_q;
   logic [31:0] wdata_q;
   logic        wr_q;
   logic        rd_q;
   logic [31:0] rdata;
   logic        enter_q;
   logic        wake_q;
   logic        lock_q;
   logic        stopped_q;
   logic        stop_req;
   logic        asleep;
   logic [15:0] pd;
   int          err_count;
   int          compares;
   int          cycles;

   lpm_power_cfg lpm_power_cfg_i (
      .clock_i           (clock_i),
      .rst_n_i           (rst_n_i),
      .addr_i            (addr_q),
      .wdata_i           (wdata_q),
      .wr_i              (wr_q),
      .rd_i              (rd_q),
      .rdata_o           (rdata),
      .sleep_enter_i     (enter_q),
      .wake_i            (wake_q),
      .wdog_lock_i       (lock_q),
      .irc_clk_stopped_i (stopped_q),
      .irc_stop_req_o    (stop_req),
      .sleep_mode_o      (asleep),
      .analog_pd_o       (pd)
   );

   // Free-running system clock, 20 ns period.
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   // Cuts a hang short; the tests need well under a thousand cycles.
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         err_count = err_count + 1;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Compares a register read result.
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("CHECK FAILED read t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Compares a level output of the sequencer.
   task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("CHECK FAILED port t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One-cycle write strobe; a gap cycle follows so strobes never collide.
   task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_q  <= a;
      wdata_q <= d;
      wr_q    <= 1'b1;
      @(posedge clock_i);
      wr_q    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample mid-cycle.
   task automatic reg_rd(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clock_i);
      addr_q <= a;
      rd_q   <= 1'b1;
      @(posedge clock_i);
      rd_q   <= 1'b0;
      @(negedge clock_i);
      chk_rd(rdata, exp);
   endtask

   // Pulses a sequencer event; returns just after the edge that takes it.
   task automatic pulse(input logic go_sleep);
      @(posedge clock_i);
      if (go_sleep) begin
         enter_q <= 1'b1;
      end else begin
         wake_q <= 1'b1;
      end
      @(posedge clock_i);
      enter_q <= 1'b0;
      wake_q  <= 1'b0;
   endtask

   // Waits for the edge after the taking edge, then samples mid-cycle.
   task automatic settle();
      @(posedge clock_i);
      @(negedge clock_i);
   endtask

   initial begin
      err_count = 0;
      compares  = 0;
      cycles    = 0;
      rst_n_i   = 1'b0;
      addr_q    = 32'h0000_0000;
      wdata_q   = 32'h0000_0000;
      wr_q      = 1'b0;
      rd_q      = 1'b0;
      enter_q   = 1'b0;
      wake_q    = 1'b0;
      lock_q    = 1'b0;
      stopped_q = 1'b0;
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(negedge clock_i);
      chk_out(pd, 16'hEDF0); // run reset
      chk_out({15'h0000, asleep}, 16'h0000); // awake
      reg_rd(LPM_SLEEP_CFG_ADDR, 32'h0000_FFFF); // reset ones
      reg_rd(LPM_WAKE_CFG_ADDR, 32'h0000_EDF0); // reset zeros
      reg_wr(32'h4004_823C, 32'h0000_1234);
      reg_rd(32'h4004_823C, 32'h0000_0000);
      // Keep brownout and watchdog on while asleep, reserved bits as ones.
      reg_wr(LPM_SLEEP_CFG_ADDR, 32'h0000_FFB7); // reserved ones
      reg_wr(LPM_WAKE_CFG_ADDR, 32'h0000_EDF9); // output and brownout off
      reg_rd(LPM_SLEEP_CFG_ADDR, 32'h0000_FFB7); // stored
      pulse(1'b1);
      @(negedge clock_i);
      chk_out({15'h0000, asleep}, 16'h0001); // asleep
      settle();
      chk_out(pd, 16'hFFB7); // forced off
      reg_rd(LPM_RUN_CFG_ADDR, 32'h0000_EDB0); // copied bits
      pulse(1'b0);
      @(negedge clock_i);
      chk_out({15'h0000, asleep}, 16'h0000); // awake again
      settle();
      chk_out(pd, 16'hEDF9); // wake state
      // A locked watchdog keeps its oscillator on despite the sleep word.
      @(posedge clock_i);
      lock_q <= 1'b1;
      reg_wr(LPM_SLEEP_CFG_ADDR, 32'h0000_FFFF); // stop asked
      pulse(1'b1);
      settle();
      chk_out(pd, 16'hFFBF); // oscillator kept
      reg_rd(LPM_RUN_CFG_ADDR, 32'h0000_EDB9); // copy masked
      pulse(1'b0);
      settle();
      chk_out(pd, 16'hEDB9); // masked on wake
      @(posedge clock_i);
      lock_q <= 1'b0;
      // Output off clears at once; oscillator stop waits for a clean clock stop.
      // The analog outputs follow the run word one edge after the write lands.
      reg_wr(LPM_RUN_CFG_ADDR, 32'h0000_EDFA); // stop asked
      settle();
      chk_out(pd, 16'hEDF8); // immediate part
      chk_out({15'h0000, stop_req}, 16'h0001); // stop pending
      repeat (3) @(posedge clock_i);
      @(negedge clock_i);
      chk_out(pd, 16'hEDF8); // still held
      @(posedge clock_i);
      stopped_q <= 1'b1;
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      chk_out(pd, 16'hEDFA); // stop applied
      reg_wr(LPM_RUN_CFG_ADDR, 32'h0000_EDF8); // power up
      stopped_q <= 1'b0;
      @(negedge clock_i);
      chk_out({15'h0000, stop_req}, 16'h0000); // request dropped
      settle();
      chk_out(pd, 16'hEDF8); // powered again
      wrap_up();
   end
endmodule
